// [logic/pmu_consts.svh]
// Offsets, field positions, reset values and counts of the power management unit
`ifndef PMU_CONSTS_SVH
`define PMU_CONSTS_SVH

// Register addresses on the special function bus
`define PMU_ADDR_POWER_CONTROL 8'h87
`define PMU_ADDR_CONFIG 8'hb5
`define PMU_ADDR_FLAGS 8'hce
`define PMU_ADDR_OUTPUT_MODE 8'hcf

// Power control fields
`define PMU_PC_USER_MSB 7
`define PMU_PC_USER_LSB 2
`define PMU_PC_STOP_BIT 1
`define PMU_PC_IDLE_BIT 0

// Configuration fields
`define PMU_CF_SLEEP_BIT 7
`define PMU_CF_SUSPEND_BIT 6
`define PMU_CF_CLEAR_BIT 5
`define PMU_CF_RST_WAKE_BIT 4
`define PMU_CF_SRC_MSB 3
`define PMU_CF_SRC_LSB 1

// Flag register fields
`define PMU_FL_SRC_MSB 1
`define PMU_FL_SRC_LSB 0

// Output mode fields
`define PMU_MD_RTC_OE_BIT 7
`define PMU_MD_WAKE_OE_BIT 6

// Wake vector positions
`define PMU_WK_CAP_SENSE 0
`define PMU_WK_SERIAL_SLAVE 1
`define PMU_WK_PORT_MATCH 2
`define PMU_WK_RTC_ALARM 3
`define PMU_WK_RTC_FAIL 4
`define PMU_WK_RESET_PIN 5
`define PMU_WK_COUNT 6

// Reset values
`define PMU_RST_BYTE 8'h00
`define PMU_RST_WAKE 6'h00

// Flags read as zero for this many clocks after leaving suspend
`define PMU_SUSPEND_BLANK_CLKS 2'h2

`endif

// [logic/pmu_pkg.sv]
// Types shared by the power management unit files
`default_nettype none
package pmu_pkg;
	typedef logic [7:0] sfr_byte_t;
	typedef logic [5:0] wake_vec_t;
	typedef enum logic [1:0] {ST_ACTIVE, ST_SUSPEND, ST_SLEEP} power_state_t;
endpackage
`default_nettype wire

// [logic/pmu_event_sync.sv]
// Two-stage synchroniser with rising edge detect for the wake event pins
`default_nettype none
`include "pmu_consts.svh"
module pmu_event_sync (
	// Clock, reset, enable
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic clk_en,
	// Raw pins, bit 6 is the buffered oscillator
	input wire logic [6:0] pin_in,
	// Synchronised level and rising edge pulse
	output logic [6:0] level_q,
	output logic [6:0] rise_q
);
	logic [6:0] meta_q; // First stage, read only by level_q
	logic [6:0] last_q; // Previous level for edge detect

	// Synchroniser chain
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			meta_q <= 7'h00;
			level_q <= 7'h00;
		end else if (clk_en) begin
			meta_q <= pin_in;
			level_q <= meta_q;
		end
	end

	// Edge detect on the settled level
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			last_q <= 7'h00;
			rise_q <= 7'h00;
		end else if (clk_en) begin
			last_q <= level_q;
			rise_q <= level_q & ~last_q;
		end
	end
endmodule
`default_nettype wire

// [logic/pmu_wake_flags.sv]
// Sticky wake flags with group clear and read blanking
`default_nettype none
`include "pmu_consts.svh"
module pmu_wake_flags
	import pmu_pkg::*;
(
	// Clock, reset, enable
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic clk_en,
	// Event pulses and clear strobe
	input wire pmu_pkg::wake_vec_t set_pulse,
	input wire logic clear_all,
	input wire logic blank,
	// Stored flags and software view
	output pmu_pkg::wake_vec_t flags_q,
	output pmu_pkg::wake_vec_t view
);
	// Set wins over a clear in the same cycle
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			flags_q <= `PMU_RST_WAKE;
		end else if (clk_en) begin
			flags_q <= (clear_all ? `PMU_RST_WAKE : flags_q) | set_pulse; // see RULE23
		end
	end

	// Flags hidden while the post-suspend settling runs
	assign view = blank ? `PMU_RST_WAKE : flags_q; // see RULE18
endmodule
`default_nettype wire

// [logic/power_mgmt_unit.sv]
// Power mode control, wake source flags and pin routing of the power management unit
//
// Functional notes
// RULE1 - Six firmware flags, bits 7..2, reset zero
// RULE2 - Stop bit write enters stop; reads zero
// RULE3 - Idle bit write enters idle; reads zero
// RULE4 - Config bit 7 write enters sleep
// RULE5 - Config bit 6 write enters suspend
// RULE6 - Config bit 5 write clears all flags
// RULE7 - Reset pin glitch sets flag bit 4
// RULE8 - Bit 3: oscillator fail flag/enable
// RULE9 - Bit 2: alarm flag/enable
// RULE10 - Config bit 1: port match flag/enable
// RULE11 - Flag reg bit 1: serial slave flag/enable
// RULE12 - Flag reg bit 0: capacitive sense flag/enable
// RULE13 - Software writes reserved bits as reset value
// RULE14 - Software avoids read-modify-write on config
// RULE15 - Software re-enables sources each low-power entry
// RULE16 - Any flag set blocks entry, oscillator on
// RULE17 - Software clears flags after reset and wake
// RULE18 - Flags read zero two clocks after suspend
// RULE19 - Mode bit 7 gates oscillator out pin
// RULE20 - Mode bit 6 gates wake request pin
// RULE21 - Flags always update, enabled or not
// RULE22 - Enables written with the mode-select write
// RULE23 - Flags sticky until clear or reset
`default_nettype none
`include "pmu_consts.svh"
module power_mgmt_unit
	import pmu_pkg::*;
(
	// Clock, reset, enable
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic clk_en,
	// Special function register port
	input wire pmu_pkg::sfr_byte_t sfr_addr,
	input wire logic sfr_wr,
	input wire pmu_pkg::sfr_byte_t sfr_wdata,
	input wire logic sfr_rd,
	output pmu_pkg::sfr_byte_t sfr_rdata,
	// Wake event pins, asynchronous
	input wire logic reset_pin_glitch,
	input wire logic rtc_osc_fail,
	input wire logic rtc_alarm,
	input wire logic port_match,
	input wire logic serial_slave_event,
	input wire logic cap_sense_event,
	// Buffered oscillator from the clock block, asynchronous
	input wire logic rtc_osc_buf,
	// Mode requests to the core
	output logic stop_req,
	output logic idle_req,
	output logic suspend_mode,
	output logic sleep_mode,
	output logic lp_osc_keep_on,
	// Port pin drives
	output logic rtc_clock_out,
	output logic wake_request_out
);
	pmu_pkg::wake_vec_t wake_pins; // Event pins gathered
	logic [6:0] sync_level; // Synchronised pin levels
	logic [6:0] sync_rise; // Synchronised rising edges
	pmu_pkg::wake_vec_t flag_set; // New events this cycle
	pmu_pkg::wake_vec_t flags; // Stored wake flags
	pmu_pkg::wake_vec_t flag_view; // Flags as software sees them
	pmu_pkg::wake_vec_t enable_q; // Wake source enables
	logic [5:0] user_flags_q; // Firmware scratch bits
	logic rtc_clock_oe_q; // Oscillator output enable
	logic wake_request_oe_q; // Wake request output enable
	logic [1:0] blank_q; // Post-suspend read blank counter
	logic clear_pulse; // Group clear strobe
	logic wake_hit; // Wake condition while asleep
	logic flags_busy; // Any flag set
	logic wr_pc; // Write to power control
	logic wr_cf; // Write to configuration
	logic wr_fl; // Write to flag register
	logic wr_md; // Write to output mode
	power_state_t state_q; // Current power state
	power_state_t state_d; // Next power state
	pmu_pkg::sfr_byte_t rdata_d; // Read mux result

	// Address match for a write strobe
	function automatic logic write_hit(input pmu_pkg::sfr_byte_t addr, input logic wr,
			input pmu_pkg::sfr_byte_t target);
		write_hit = wr && (addr == target);
	endfunction

	// Register write decode
	assign wr_pc = write_hit(sfr_addr, sfr_wr, `PMU_ADDR_POWER_CONTROL);
	assign wr_cf = write_hit(sfr_addr, sfr_wr, `PMU_ADDR_CONFIG);
	assign wr_fl = write_hit(sfr_addr, sfr_wr, `PMU_ADDR_FLAGS);
	assign wr_md = write_hit(sfr_addr, sfr_wr, `PMU_ADDR_OUTPUT_MODE);

	// Gather event pins into the wake vector order
	always_comb begin
		wake_pins = `PMU_RST_WAKE;
		wake_pins[`PMU_WK_CAP_SENSE] = cap_sense_event;
		wake_pins[`PMU_WK_SERIAL_SLAVE] = serial_slave_event;
		wake_pins[`PMU_WK_PORT_MATCH] = port_match;
		wake_pins[`PMU_WK_RTC_ALARM] = rtc_alarm;
		wake_pins[`PMU_WK_RTC_FAIL] = rtc_osc_fail;
		wake_pins[`PMU_WK_RESET_PIN] = reset_pin_glitch;
	end

	// Pins cross into the system clock before any logic uses them
	pmu_event_sync u_sync (
		.clock(clock),
		.sys_rst(sys_rst),
		.clk_en(clk_en),
		.pin_in({rtc_osc_buf, wake_pins}),
		.level_q(sync_level),
		.rise_q(sync_rise)
	);

	// Every event sets its flag whatever the enables say
	assign flag_set = sync_rise[5:0]; // see RULE21 see RULE7

	// Group clear from the configuration register
	assign clear_pulse = wr_cf && sfr_wdata[`PMU_CF_CLEAR_BIT]; // see RULE6

	// Sticky flag storage
	pmu_wake_flags u_flags (
		.clock(clock),
		.sys_rst(sys_rst),
		.clk_en(clk_en),
		.set_pulse(flag_set),
		.clear_all(clear_pulse),
		.blank(blank_q != 2'h0),
		.flags_q(flags),
		.view(flag_view)
	);

	// Any flag blocks deep modes and holds the oscillator
	assign flags_busy = |flags; // see RULE16

	// Enabled source or reset pin ends suspend and sleep
	assign wake_hit = |(flag_set & enable_q) || flag_set[`PMU_WK_RESET_PIN];

	// Firmware scratch bits in power control
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			user_flags_q <= 6'h00;
		end else if (clk_en && wr_pc) begin
			user_flags_q <= sfr_wdata[`PMU_PC_USER_MSB:`PMU_PC_USER_LSB]; // see RULE1
		end
	end

	// Stop and idle requests, one clock pulse each
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			stop_req <= 1'b0;
			idle_req <= 1'b0;
		end else if (clk_en) begin
			stop_req <= wr_pc && sfr_wdata[`PMU_PC_STOP_BIT]; // see RULE2
			idle_req <= wr_pc && sfr_wdata[`PMU_PC_IDLE_BIT]; // see RULE3
		end
	end

	// Wake source enables, written from both registers
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			enable_q <= `PMU_RST_WAKE;
		end else if (clk_en) begin
			if (state_q != ST_ACTIVE && state_d == ST_ACTIVE) begin
				// Enables spent on wake, software arms them again
				enable_q <= `PMU_RST_WAKE; // see RULE15
			end else begin
				if (wr_cf) begin
					// Write sets enables, a read would show flags
					enable_q[`PMU_WK_RTC_FAIL] <= sfr_wdata[3]; // see RULE8
					enable_q[`PMU_WK_RTC_ALARM] <= sfr_wdata[2]; // see RULE9
					enable_q[`PMU_WK_PORT_MATCH] <= sfr_wdata[1]; // see RULE10
				end
				if (wr_fl) begin
					enable_q[`PMU_WK_SERIAL_SLAVE] <= sfr_wdata[1]; // see RULE11
					enable_q[`PMU_WK_CAP_SENSE] <= sfr_wdata[0]; // see RULE12
				end
			end
		end
	end

	// Next power state
	always_comb begin
		state_d = state_q;
		case (state_q)
			ST_ACTIVE: begin
				// Entry refused while any flag is up
				if (wr_cf && !flags_busy && !clear_pulse) begin // see RULE16
					if (sfr_wdata[`PMU_CF_SLEEP_BIT]) begin
						state_d = ST_SLEEP; // see RULE4
					end else if (sfr_wdata[`PMU_CF_SUSPEND_BIT]) begin
						state_d = ST_SUSPEND; // see RULE5
					end
				end
			end
			ST_SUSPEND: begin
				// Leave on an enabled event
				if (wake_hit) begin
					state_d = ST_ACTIVE;
				end
			end
			ST_SLEEP: begin
				// Leave on an enabled event
				if (wake_hit) begin
					state_d = ST_ACTIVE;
				end
			end
			default: begin
				state_d = ST_ACTIVE;
			end
		endcase
	end

	// Power state register
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			state_q <= ST_ACTIVE;
		end else if (clk_en) begin
			state_q <= state_d;
		end
	end

	// Blank counter started on leaving suspend
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			blank_q <= 2'h0;
		end else if (clk_en) begin
			if (state_q == ST_SUSPEND && state_d == ST_ACTIVE) begin
				blank_q <= `PMU_SUSPEND_BLANK_CLKS; // see RULE18
			end else if (blank_q != 2'h0) begin
				blank_q <= blank_q - 2'h1;
			end
		end
	end

	// Mode status and oscillator hold
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			suspend_mode <= 1'b0;
			sleep_mode <= 1'b0;
			lp_osc_keep_on <= 1'b0;
		end else if (clk_en) begin
			suspend_mode <= (state_d == ST_SUSPEND);
			sleep_mode <= (state_d == ST_SLEEP);
			lp_osc_keep_on <= flags_busy || (|flag_set); // see RULE16
		end
	end

	// Pin output enables in the output mode register
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			rtc_clock_oe_q <= 1'b0;
			wake_request_oe_q <= 1'b0;
		end else if (clk_en && wr_md) begin
			rtc_clock_oe_q <= sfr_wdata[`PMU_MD_RTC_OE_BIT];
			wake_request_oe_q <= sfr_wdata[`PMU_MD_WAKE_OE_BIT];
		end
	end

	// Gated pin drives, registered
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			rtc_clock_out <= 1'b0;
			wake_request_out <= 1'b0;
		end else if (clk_en) begin
			rtc_clock_out <= rtc_clock_oe_q && sync_level[6]; // see RULE19
			wake_request_out <= wake_request_oe_q && (state_q == ST_SLEEP)
				&& wake_hit; // see RULE20
		end
	end

	// Read mux, command and reserved bits read zero
	always_comb begin
		rdata_d = `PMU_RST_BYTE;
		case (sfr_addr)
			`PMU_ADDR_POWER_CONTROL: begin
				rdata_d = {user_flags_q, 2'b00}; // see RULE2 see RULE3
			end
			`PMU_ADDR_CONFIG: begin
				rdata_d = {3'b000, flag_view[`PMU_WK_RESET_PIN],
					flag_view[`PMU_WK_RTC_FAIL], flag_view[`PMU_WK_RTC_ALARM],
					flag_view[`PMU_WK_PORT_MATCH], 1'b0};
			end
			`PMU_ADDR_FLAGS: begin
				rdata_d = {6'h00, flag_view[`PMU_WK_SERIAL_SLAVE],
					flag_view[`PMU_WK_CAP_SENSE]};
			end
			`PMU_ADDR_OUTPUT_MODE: begin
				rdata_d = {rtc_clock_oe_q, wake_request_oe_q, 6'h00};
			end
			default: begin
				rdata_d = `PMU_RST_BYTE;
			end
		endcase
	end

	// Read data captured on the read strobe
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			sfr_rdata <= `PMU_RST_BYTE;
		end else if (clk_en && sfr_rd) begin
			sfr_rdata <= rdata_d;
		end
	end
endmodule
`default_nettype wire

// [verif/power_mgmt_unit_sva.sv]
// Assertion checker for the power management unit ports
`default_nettype none
module power_mgmt_unit_sva (
	// Clock and reset
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic clk_en,
	// Register port
	input wire pmu_pkg::sfr_byte_t sfr_addr,
	input wire logic sfr_wr,
	input wire pmu_pkg::sfr_byte_t sfr_wdata,
	input wire logic sfr_rd,
	input wire pmu_pkg::sfr_byte_t sfr_rdata,
	// Mode and pin outputs
	input wire logic stop_req,
	input wire logic idle_req,
	input wire logic suspend_mode,
	input wire logic sleep_mode,
	input wire logic lp_osc_keep_on,
	input wire logic rtc_clock_out,
	input wire logic wake_request_out
);
	default clocking @(posedge clock); endclocking
	default disable iff (sys_rst);
	wire logic wr = sfr_wr && clk_en; // Accepted write
	wire logic rd = sfr_rd && clk_en; // Accepted read
	wire logic act = !sleep_mode && !suspend_mode; // Running
	wire logic cfw = wr && sfr_addr == 8'hb5; // Config write
	logic [5:0] uf_q; // Mirror of firmware flags
	logic [1:0] md_q; // Mirror of pin enables
	// Mirrors follow accepted writes
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			uf_q <= 6'h00;
			md_q <= 2'h0;
		end else begin
			if (wr && sfr_addr == 8'h87) uf_q <= sfr_wdata[7:2];
			if (wr && sfr_addr == 8'hcf) md_q <= sfr_wdata[7:6];
		end
	end
	AST_STOP: assert property (
		wr && sfr_addr == 8'h87 && sfr_wdata[1] |=> stop_req)
		else $error("stop request missing");
	AST_IDLE: assert property (
		wr && sfr_addr == 8'h87 && sfr_wdata[0] |=> idle_req)
		else $error("idle request missing");
	AST_PC_READ: assert property (
		rd && sfr_addr == 8'h87 |=> sfr_rdata == {$past(uf_q), 2'h0})
		else $error("power control read wrong");
	AST_MD_READ: assert property (
		rd && sfr_addr == 8'hcf |=> sfr_rdata == {$past(md_q), 6'h00})
		else $error("output mode read wrong");
	AST_FL_READ: assert property (
		rd && sfr_addr == 8'hce |=> sfr_rdata[7:2] == 6'h00)
		else $error("flag register upper bits set");
	// Oscillator hold lags a clear by one cycle, so skip the cycle after one
	AST_SLEEP_NO: assert property (
		cfw && sfr_wdata[7] && lp_osc_keep_on && act && !$past(cfw && sfr_wdata[5])
		|=> !sleep_mode)
		else $error("sleep entered with flag set");
	AST_SUSP_NO: assert property (
		cfw && sfr_wdata[6] && lp_osc_keep_on && act && !$past(cfw && sfr_wdata[5])
		|=> !suspend_mode)
		else $error("suspend entered with flag set");
	AST_SLEEP_GO: assert property (
		cfw && sfr_wdata[7:5] == 3'h4 && !lp_osc_keep_on && act |=> sleep_mode)
		else $error("sleep not entered");
	AST_SUSP_GO: assert property (
		cfw && sfr_wdata[7:5] == 3'h2 && !lp_osc_keep_on && act |=> suspend_mode)
		else $error("suspend not entered");
	AST_RTC_OUT: assert property (
		(!md_q[1]) [*2] |-> !rtc_clock_out)
		else $error("oscillator out while disabled");
	AST_WAKE_OUT: assert property (
		wake_request_out |-> md_q[0] && (sleep_mode || $past(sleep_mode)))
		else $error("wake request out of place");
endmodule
bind power_mgmt_unit power_mgmt_unit_sva i_sva (.clock(clock), .sys_rst(sys_rst), .clk_en(clk_en),
	.sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd),
	.sfr_rdata(sfr_rdata), .stop_req(stop_req), .idle_req(idle_req), .suspend_mode(suspend_mode),
	.sleep_mode(sleep_mode), .lp_osc_keep_on(lp_osc_keep_on), .rtc_clock_out(rtc_clock_out),
	.wake_request_out(wake_request_out));
`default_nettype wire

// [verif/tb_power_mgmt_unit.sv]
// Self-checking bench for the power management unit
`default_nettype none
module tb_power_mgmt_unit;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct packed {logic [7:0] a; logic [7:0] d; logic [7:0] e; logic [1:0] p;} row_t;
	logic clock = 1'b0;
	logic sys_rst = 1'b1;
	logic clk_en = 1'b1;
	pmu_pkg::sfr_byte_t sfr_addr = 8'h00;
	pmu_pkg::sfr_byte_t sfr_wdata = 8'h00;
	pmu_pkg::sfr_byte_t sfr_rdata;
	pmu_pkg::sfr_byte_t rv; // Last read value
	logic sfr_wr = 1'b0;
	logic sfr_rd = 1'b0;
	logic [5:0] ev = 6'h00; // Event pins in wake vector order
	logic osc = 1'b0;
	logic stop_req, idle_req, suspend_mode, sleep_mode, keep_on, rtc_out, wake_out;
	logic woke = 1'b0; // Wake request pulse seen
	int n_mismatch = 0;
	int cmp_count = 0;
	// Write, then read back, with expected read and requests
	// Reserved bits of mapped registers are written as zero; the unmapped address 8'h12 gets 8'hff
	row_t rows [8] = '{'{8'h87, 8'hff, 8'hfc, 2'h3}, '{8'h87, 8'ha6, 8'ha4, 2'h2},
		'{8'h87, 8'h01, 8'h00, 2'h1}, '{8'hcf, 8'hc0, 8'hc0, 2'h0}, '{8'hcf, 8'h40, 8'h40, 2'h0},
		'{8'hce, 8'h03, 8'h00, 2'h0}, '{8'hb5, 8'h0e, 8'h00, 2'h0}, '{8'h12, 8'hff, 8'h00, 2'h0}};
	logic [7:0] fl [6] = '{8'h01, 8'h02, 8'h02, 8'h04, 8'h08, 8'h10}; // Flag per event
	always #20 clock = ~clock;
	power_mgmt_unit i_dut (.clock(clock), .sys_rst(sys_rst), .clk_en(clk_en), .sfr_addr(sfr_addr),
		.sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
		.reset_pin_glitch(ev[5]), .rtc_osc_fail(ev[4]), .rtc_alarm(ev[3]), .port_match(ev[2]),
		.serial_slave_event(ev[1]), .cap_sense_event(ev[0]), .rtc_osc_buf(osc),
		.stop_req(stop_req), .idle_req(idle_req), .suspend_mode(suspend_mode),
		.sleep_mode(sleep_mode), .lp_osc_keep_on(keep_on), .rtc_clock_out(rtc_out),
		.wake_request_out(wake_out));
	// Catch the one-cycle wake request
	always @(posedge clock) begin
		if (wake_out === 1'b1) woke <= 1'b1;
	end
	task automatic chk(input string n, input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] %s exp %h got %h", n, exp, got);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		sfr_addr = a;
		sfr_wdata = d;
		sfr_wr = 1'b1;
		@(negedge clock);
		sfr_wr = 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		sfr_addr = a;
		sfr_rd = 1'b1;
		@(negedge clock);
		sfr_rd = 1'b0;
		@(negedge clock);
		rv = sfr_rdata;
	endtask
	task automatic pulse(input int i);
		ev[i] = 1'b1;
		repeat (4) @(negedge clock);
		ev[i] = 1'b0;
		repeat (4) @(negedge clock);
	endtask
	// Clear all flags and confirm, config always written whole
	task automatic clr();
		wr(8'hb5, 8'h20);
		rd(8'hb5);
		chk("clear", rv, 8'h00);
		chk("keep_off", 8'(keep_on), 8'h00);
	endtask
	task automatic end_of_test();
		$display("compares %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	// Watchdog
	initial begin
		#60000;
		n_mismatch++;
		end_of_test();
	end
	initial begin
		repeat (8) @(negedge clock);
		sys_rst = 1'b0;
		@(negedge clock);
		chk("out_rst", 8'({stop_req, idle_req, suspend_mode, sleep_mode, keep_on, rtc_out}),
			8'h00);
		foreach (rows[i]) begin
			rd(rows[i].a);
			chk("reg_rst", rv, 8'h00);
		end
		foreach (rows[i]) begin
			wr(rows[i].a, rows[i].d);
			chk("req", 8'({stop_req, idle_req}), 8'(rows[i].p));
			rd(rows[i].a);
			chk("row", rv, rows[i].e);
		end
		// Writes with the clock enable low are dropped
		clk_en = 1'b0;
		wr(8'h87, 8'h08);
		clk_en = 1'b1;
		rd(8'h87);
		chk("frozen", rv, 8'h00);
		// Each event sets its flag and blocks low power entry
		foreach (fl[i]) begin
			clr();
			pulse(i);
			rd(i < 2 ? 8'hce : 8'hb5);
			chk("flag", rv, fl[i]);
			chk("keep_on", 8'(keep_on), 8'h01);
			wr(8'hb5, 8'hc0);
			chk("refused", 8'({sleep_mode, suspend_mode}), 8'h00);
			rd(i < 2 ? 8'hce : 8'hb5);
			chk("sticky", rv, fl[i]);
		end
		clr();
		wr(8'hb5, 8'h84);
		chk("sleep", 8'(sleep_mode), 8'h01);
		pulse(3);
		chk("wake", 8'({sleep_mode, woke}), 8'h01);
		rd(8'hb5);
		chk("cause", rv, 8'h04);
		clr();
		wr(8'hb5, 8'h44);
		chk("suspend", 8'(suspend_mode), 8'h01);
		ev[3] = 1'b1;
		for (int k = 0; k < 20 && suspend_mode; k++) @(negedge clock);
		chk("left_susp", 8'(suspend_mode), 8'h00);
		rd(8'hb5);
		chk("blank", rv, 8'h00);
		ev[3] = 1'b0;
		rd(8'hb5);
		chk("later", rv, 8'h04);
		// Buffered oscillator routed only while enabled
		osc = 1'b1;
		wr(8'hcf, 8'h80);
		repeat (4) @(negedge clock);
		chk("rtc_on", 8'(rtc_out), 8'h01);
		// Output follows the oscillator level, not just the enable
		osc = 1'b0;
		repeat (4) @(negedge clock);
		chk("rtc_low", 8'(rtc_out), 8'h00);
		osc = 1'b1;
		repeat (4) @(negedge clock);
		chk("rtc_high", 8'(rtc_out), 8'h01);
		wr(8'hcf, 8'h00);
		repeat (3) @(negedge clock);
		chk("rtc_off", 8'(rtc_out), 8'h00);
		// Reset in mid-run clears firmware bits, flags and outputs
		wr(8'h87, 8'hfc);
		pulse(5);
		sys_rst = 1'b1;
		repeat (2) @(negedge clock);
		sys_rst = 1'b0;
		@(negedge clock);
		chk("mid_out", 8'({keep_on, rtc_out, wake_out}), 8'h00);
		rd(8'h87);
		chk("mid_pc", rv, 8'h00);
		rd(8'hb5);
		chk("mid_flag", rv, 8'h00);
		end_of_test();
	end
endmodule
`default_nettype wire
